// ===== design/fdsr_pkg.sv
// shared constants, register layouts and types of the flash divider and security registers
package fdsr_pkg;

    // register byte addresses on the bus
    localparam logic [11:0] ADDR_DIVIDER = 12'h000;
    localparam logic [11:0] ADDR_OPTIONS = 12'h004;
    localparam logic [11:0] ADDR_CONFIG = 12'h008;
    localparam int ADDR_WIDTH = 12;

    // divider register fields
    localparam int DIV_LOAD_BIT = 7;
    localparam int DIV_PRESCALE_BIT = 6;
    localparam int DIV_VALUE_MSB = 5;
    localparam int DIV_VALUE_LSB = 0;
    localparam logic [2:0] PRESCALE_LAST = 3'h7;
    localparam logic [5:0] DIV_VALUE_ZERO = 6'h00;
    localparam logic [2:0] PRESCALE_ZERO = 3'h0;

    // options register fields and codes
    localparam logic [1:0] BACKDOOR_ENABLED_CODE = 2'h2;
    localparam logic [1:0] SECURITY_UNSECURED_A = 2'h0;
    localparam logic [1:0] SECURITY_UNSECURED_B = 2'h3;
    localparam logic [1:0] SECURITY_FORCED = 2'h3;
    localparam logic [3:0] OPTIONS_RESERVED_READ = 4'h0;
    localparam logic [7:0] OPTIONS_RESET = 8'h00;

    // configuration register fields
    localparam int KEY_ACCESS_BIT = 5;
    localparam logic KEY_ACCESS_RESET = 1'b0;

    // key length used by the comparison logic outside this block
    localparam int KEY_BYTES = 8;

    // bus encodings
    localparam logic HTRANS_ACTIVE_BIT = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic load_lock;
        logic prescale_by_eight;
        logic [5:0] divider_value;
    } fdsr_divider_type;

    typedef struct packed {
        logic [1:0] backdoor_enable;
        logic [3:0] reserved;
        logic [1:0] security_state;
    } fdsr_options_type;

    localparam fdsr_divider_type DIVIDER_RESET = 8'h00;

    typedef enum logic [3:0] {
        BUS_IDLE = 4'h1,
        BUS_WRITE = 4'h2,
        BUS_READ_WAIT = 4'h4,
        BUS_READ_DONE = 4'h8
    } fdsr_bus_state_type;

endpackage

// ===== design/fdsr_timebase.sv
// prescaler and divider that produce the flash timing tick
`timescale 1ns/1ps
`default_nettype none
module fdsr_timebase (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic i_prescale,
    input wire logic [5:0] i_div,
    output logic o_tick
);
    logic [2:0] pre_cnt;
    logic [5:0] div_cnt;
    logic pre_tick;

    // prescale by eight or pass every bus clock [RQ4]
    assign pre_tick = i_prescale ? (pre_cnt == fdsr_pkg::PRESCALE_LAST) : 1'b1;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_cnt <= fdsr_pkg::PRESCALE_ZERO;
        end else if (i_ce) begin
            if (!i_run || !i_prescale) begin
                pre_cnt <= fdsr_pkg::PRESCALE_ZERO;
            end else begin
                pre_cnt <= pre_cnt + 3'h1;
            end
        end
    end

    // ratio is (divider+1) times the prescale [RQ5] [RQ7]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_cnt <= fdsr_pkg::DIV_VALUE_ZERO;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                div_cnt <= fdsr_pkg::DIV_VALUE_ZERO;
                o_tick <= 1'b0;
            end else if (pre_tick && div_cnt >= i_div) begin
                div_cnt <= fdsr_pkg::DIV_VALUE_ZERO;
                o_tick <= 1'b1;
            end else begin
                div_cnt <= pre_tick ? div_cnt + 6'h01 : div_cnt;
                o_tick <= 1'b0;
            end
        end
    end

    logic cfg_two;
    assign cfg_two = i_ce && i_run && !i_prescale && (i_div == 6'h01);

    property p_ratio_two;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_tick && cfg_two) ##1 cfg_two |-> !o_tick ##1 o_tick;
    endproperty
    a_ratio_two: assert property (p_ratio_two) // [RQ5]
        else $error("divide by two tick spacing wrong");

    property p_prescale_gap;
        @(posedge i_clk) disable iff (!i_rstn)
        (o_tick && i_ce && i_run && i_prescale) |=> !o_tick;
    endproperty
    a_prescale_gap: assert property (p_prescale_gap) // [RQ4]
        else $error("prescaled tick too close");

endmodule
`default_nettype wire

// ===== design/fdsr_top.sv
// flash clock divider, security options and key access configuration registers
// Function
// RQ1 - first divider write with lock bit 0 locks divider until reset
// RQ2 - first divider write with lock bit 1 keeps divider writable
// RQ3 - lock bit reads 0 until divider written since reset, then 1
// RQ4 - prescale bit chooses bus clock direct or divided by eight
// RQ5 - total divide ratio from 2 up to 512; code also gives 1 with divider 0 and no prescale
// RQ6 - software picks settings giving 150 to 200 kHz timing clock
// RQ7 - program and erase timing runs from the divided tick
// RQ8 - options register fully readable, writes have no effect
// RQ9 - options register loaded from stored flash byte at reset
// RQ10 - backdoor enabled only for code 10, all others disable it
// RQ11 - security codes 00 and 11 report unsecured
// RQ12 - successful backdoor key unlock forces security to unsecured
// RQ13 - key access bit writable only while backdoor enabled, others read 0
// RQ14 - key access 0 means command start, 1 means key writes
// RQ15 - array reads keep working while key access is set
// RQ16 - eight byte key usable only while backdoor enabling active
// RQ17 - security codes 01 and 10 report secured
// RQ18 - software writes zero to reserved bits, ignores their reads
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fdsr_top (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_hsel,
    input wire logic [11:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic i_hready,
    input wire logic [31:0] i_hwdata,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [7:0] i_stored_options_byte,
    input wire logic i_key_unlock,
    input wire logic i_array_write,
    input wire logic i_array_read,
    output logic o_array_read_grant,
    output logic o_cmd_write_start,
    output logic o_key_write,
    output logic o_timing_tick,
    output logic o_backdoor_enabled,
    output logic o_secured,
    output logic o_key_write_access
);
    fdsr_pkg::fdsr_bus_state_type state;
    fdsr_pkg::fdsr_bus_state_type next_state;
    fdsr_pkg::fdsr_divider_type divider;
    fdsr_pkg::fdsr_options_type options;
    logic [11:0] addr_q;
    logic accept;
    logic write_commit;
    logic div_written;
    logic div_locked;
    logic options_loaded;
    logic key_access;
    logic [7:0] read_byte;
    logic [7:0] wbyte;

    // address phase taken only while the bus is ready
    assign accept = i_hsel && (i_htrans[1] == fdsr_pkg::HTRANS_ACTIVE_BIT) && i_hready;
    assign write_commit = i_ce && (state == fdsr_pkg::BUS_WRITE);
    assign wbyte = i_hwdata[7:0];

    always_comb begin
        next_state = fdsr_pkg::BUS_IDLE;
        case (state)
            fdsr_pkg::BUS_READ_WAIT: begin
                next_state = fdsr_pkg::BUS_READ_DONE;
            end
            fdsr_pkg::BUS_IDLE, fdsr_pkg::BUS_WRITE, fdsr_pkg::BUS_READ_DONE: begin
                if (accept) begin
                    next_state = i_hwrite ? fdsr_pkg::BUS_WRITE : fdsr_pkg::BUS_READ_WAIT;
                end
            end
            default: begin
                next_state = fdsr_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= fdsr_pkg::BUS_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            addr_q <= fdsr_pkg::ADDR_DIVIDER;
        end else if (i_ce && accept && state != fdsr_pkg::BUS_READ_WAIT) begin
            addr_q <= i_haddr;
        end
    end

    // one wait state on reads so a write just before is already visible;
    // held low while frozen, else a master would see a transfer that never landed
    assign o_hreadyout = i_ce && (state != fdsr_pkg::BUS_READ_WAIT);
    assign o_hresp = fdsr_pkg::HRESP_OKAY;

    // divider register and its write history [RQ1] [RQ2] [RQ3]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            divider <= fdsr_pkg::DIVIDER_RESET;
            div_written <= 1'b0;
            div_locked <= 1'b0;
        end else if (write_commit && addr_q == fdsr_pkg::ADDR_DIVIDER && !div_locked) begin
            divider.prescale_by_eight <= wbyte[fdsr_pkg::DIV_PRESCALE_BIT];
            divider.divider_value <= wbyte[fdsr_pkg::DIV_VALUE_MSB:fdsr_pkg::DIV_VALUE_LSB];
            divider.load_lock <= 1'b1;
            div_written <= 1'b1;
            div_locked <= !wbyte[fdsr_pkg::DIV_LOAD_BIT];
        end
    end

    // options copied from the stored byte on the first enabled cycle after reset [RQ9]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            options <= fdsr_pkg::OPTIONS_RESET;
            options_loaded <= 1'b0;
        end else if (i_ce) begin
            if (!options_loaded) begin
                options <= i_stored_options_byte;
                options_loaded <= 1'b1;
            end else if (i_key_unlock) begin
                options.security_state <= fdsr_pkg::SECURITY_FORCED; // [RQ12]
            end
        end
    end

    // options are never written from the bus [RQ8]
    assign o_backdoor_enabled =
        (options.backdoor_enable == fdsr_pkg::BACKDOOR_ENABLED_CODE); // [RQ10]
    // codes not listed as unsecured count as secured [RQ11] [RQ17]
    assign o_secured = !((options.security_state == fdsr_pkg::SECURITY_UNSECURED_A)
                       || (options.security_state == fdsr_pkg::SECURITY_UNSECURED_B));

    // key access bit gated by the backdoor enable [RQ13]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            key_access <= fdsr_pkg::KEY_ACCESS_RESET;
        end else if (write_commit && addr_q == fdsr_pkg::ADDR_CONFIG && o_backdoor_enabled) begin
            key_access <= wbyte[fdsr_pkg::KEY_ACCESS_BIT];
        end
    end
    assign o_key_write_access = key_access;

    // array writes steered to command start or key entry [RQ14]
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cmd_write_start <= 1'b0;
            o_key_write <= 1'b0;
        end else if (i_ce) begin
            o_cmd_write_start <= i_array_write && !key_access;
            // key bytes honoured only while enabling is active [RQ16]
            o_key_write <= i_array_write && key_access && o_backdoor_enabled;
        end
    end

    // reads pass regardless of key access [RQ15]
    assign o_array_read_grant = i_array_read;

    always_comb begin
        read_byte = 8'h00;
        case (addr_q)
            fdsr_pkg::ADDR_DIVIDER: begin
                read_byte = {div_written, divider.prescale_by_eight,
                             divider.divider_value}; // [RQ3]
            end
            fdsr_pkg::ADDR_OPTIONS: begin
                read_byte = {options.backdoor_enable, fdsr_pkg::OPTIONS_RESERVED_READ,
                             options.security_state};
            end
            fdsr_pkg::ADDR_CONFIG: begin
                read_byte = 8'h00;
                read_byte[fdsr_pkg::KEY_ACCESS_BIT] = key_access;
            end
            default: begin
                read_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hrdata <= fdsr_pkg::RDATA_ZERO;
        end else if (i_ce && state == fdsr_pkg::BUS_READ_WAIT) begin
            o_hrdata <= {24'h000000, read_byte};
        end
    end

    // timing tick runs only once a divider has been written [RQ7]
    fdsr_timebase u_timebase (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_run(div_written),
        .i_prescale(divider.prescale_by_eight),
        .i_div(divider.divider_value),
        .o_tick(o_timing_tick)
    );

    logic div_wr_attempt;
    logic cfg_wr_attempt;
    logic opt_wr_attempt;
    assign div_wr_attempt = write_commit && addr_q == fdsr_pkg::ADDR_DIVIDER;
    assign cfg_wr_attempt = write_commit && addr_q == fdsr_pkg::ADDR_CONFIG;
    assign opt_wr_attempt = write_commit && addr_q == fdsr_pkg::ADDR_OPTIONS;

    property p_first_write_locks;
        @(posedge i_clk) disable iff (!i_rstn)
        (div_wr_attempt && !div_written && !wbyte[fdsr_pkg::DIV_LOAD_BIT]) |=> div_locked;
    endproperty
    a_first_write_locks: assert property (p_first_write_locks) // [RQ1]
        else $error("divider not locked");

    property p_locked_ignores;
        @(posedge i_clk) disable iff (!i_rstn)
        (div_wr_attempt && div_locked) |=> $stable(divider);
    endproperty
    a_locked_ignores: assert property (p_locked_ignores) // [RQ1]
        else $error("locked divider changed");

    property p_open_accepts;
        @(posedge i_clk) disable iff (!i_rstn)
        (div_wr_attempt && !div_written && wbyte[fdsr_pkg::DIV_LOAD_BIT])
        |=> !div_locked && divider.divider_value == $past(wbyte[5:0]);
    endproperty
    a_open_accepts: assert property (p_open_accepts) // [RQ2]
        else $error("divider write not kept open");

    property p_load_bit_read;
        @(posedge i_clk) disable iff (!i_rstn)
        (state == fdsr_pkg::BUS_READ_DONE && addr_q == fdsr_pkg::ADDR_DIVIDER)
        |-> o_hrdata[fdsr_pkg::DIV_LOAD_BIT] == div_written;
    endproperty
    a_load_bit_read: assert property (p_load_bit_read) else $error("load bit read wrong"); // [RQ3]

    property p_options_readonly;
        @(posedge i_clk) disable iff (!i_rstn)
        (opt_wr_attempt && options_loaded && !i_key_unlock) |=> $stable(options);
    endproperty
    a_options_readonly: assert property (p_options_readonly) // [RQ8]
        else $error("options written");

    property p_backdoor_code;
        @(posedge i_clk) disable iff (!i_rstn)
        o_backdoor_enabled |-> options.backdoor_enable == 2'h2;
    endproperty
    a_backdoor_code: assert property (p_backdoor_code) // [RQ10]
        else $error("backdoor enable decode wrong");

    property p_secured_decode;
        @(posedge i_clk) disable iff (!i_rstn)
        o_secured |-> (options.security_state == 2'h1 || options.security_state == 2'h2);
    endproperty
    a_secured_decode: assert property (p_secured_decode) // [RQ17]
        else $error("security decode wrong");

    property p_unlock_forces;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && options_loaded && i_key_unlock) |=> !o_secured;
    endproperty
    a_unlock_forces: assert property (p_unlock_forces) // [RQ12]
        else $error("unlock did not unsecure");

    property p_key_access_gate;
        @(posedge i_clk) disable iff (!i_rstn)
        (cfg_wr_attempt && !o_backdoor_enabled) |=> $stable(key_access);
    endproperty
    a_key_access_gate: assert property (p_key_access_gate) // [RQ13]
        else $error("key access written");

    property p_steer_write;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && i_array_write)
        |=> (o_cmd_write_start != $past(key_access)) && !(o_cmd_write_start && o_key_write);
    endproperty
    a_steer_write: assert property (p_steer_write) // [RQ14]
        else $error("array write steered wrong");

    property p_read_wait;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && accept && !i_hwrite) |=> !o_hreadyout ##1 o_hreadyout [*1];
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong"); // [RQ3]

    property p_key_access_write;
        @(posedge i_clk) disable iff (!i_rstn)
        (cfg_wr_attempt && o_backdoor_enabled)
        |=> key_access == $past(wbyte[fdsr_pkg::KEY_ACCESS_BIT]);
    endproperty
    a_key_access_write: assert property (p_key_access_write) // [RQ13]
        else $error("key access bit not taken");

    property p_config_read;
        @(posedge i_clk) disable iff (!i_rstn)
        (state == fdsr_pkg::BUS_READ_DONE && addr_q == fdsr_pkg::ADDR_CONFIG)
        |-> o_hrdata == {24'h000000, 2'h0, key_access, 5'h00};
    endproperty
    a_config_read: assert property (p_config_read) // [RQ13]
        else $error("config read wrong");

    property p_options_read;
        @(posedge i_clk) disable iff (!i_rstn)
        (state == fdsr_pkg::BUS_READ_DONE && addr_q == fdsr_pkg::ADDR_OPTIONS)
        |-> o_hrdata[7:2] == {options.backdoor_enable, 4'h0};
    endproperty
    a_options_read: assert property (p_options_read) // [RQ8]
        else $error("options read wrong");

    property p_options_load;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && !options_loaded) |=> options == $past(i_stored_options_byte);
    endproperty
    a_options_load: assert property (p_options_load) // [RQ9]
        else $error("options not loaded from stored byte");

    property p_unsecured_decode;
        @(posedge i_clk) disable iff (!i_rstn)
        !o_secured |-> (options.security_state == 2'h0 || options.security_state == 2'h3);
    endproperty
    a_unsecured_decode: assert property (p_unsecured_decode) // [RQ11]
        else $error("unsecured decode wrong");

    property p_key_needs_enable;
        @(posedge i_clk) disable iff (!i_rstn)
        o_key_write |-> $past(o_backdoor_enabled) && $past(key_access);
    endproperty
    a_key_needs_enable: assert property (p_key_needs_enable) // [RQ16]
        else $error("key write without enable");

    property p_read_grant;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_array_read && key_access) |-> o_array_read_grant;
    endproperty
    a_read_grant: assert property (p_read_grant) // [RQ15]
        else $error("array read refused during key access");

    property p_lock_holds;
        @(posedge i_clk) disable iff (!i_rstn)
        div_locked |=> div_locked && div_written;
    endproperty
    a_lock_holds: assert property (p_lock_holds) // [RQ1]
        else $error("divider lock released");

    property p_tick_idle;
        @(posedge i_clk) disable iff (!i_rstn)
        !div_written |-> !o_timing_tick;
    endproperty
    a_tick_idle: assert property (p_tick_idle) // [RQ7]
        else $error("tick before divider written");

endmodule
`default_nettype wire

// ===== tb/tb_fdsr_top.sv
// self-checking bench for the flash divider and security registers
`timescale 1ns/1ps
`default_nettype none
module tb_fdsr_top;
    logic i_clk, i_rstn, i_ce, i_hsel, i_hwrite, i_key_unlock, i_array_write, i_array_read;
    logic [11:0] i_haddr;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic [31:0] i_hwdata, o_hrdata, rd;
    logic [7:0] i_stored_options_byte;
    logic [1:0] k;
    logic o_hreadyout, o_hresp, o_array_read_grant, o_cmd_write_start, o_key_write;
    logic o_timing_tick, o_backdoor_enabled, o_secured, o_key_write_access;
    int n_fail, checked;
    int m;

    fdsr_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hready(o_hreadyout), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .i_stored_options_byte(i_stored_options_byte), .i_key_unlock(i_key_unlock),
        .i_array_write(i_array_write), .i_array_read(i_array_read),
        .o_array_read_grant(o_array_read_grant), .o_cmd_write_start(o_cmd_write_start),
        .o_key_write(o_key_write), .o_timing_tick(o_timing_tick),
        .o_backdoor_enabled(o_backdoor_enabled), .o_secured(o_secured),
        .o_key_write_access(o_key_write_access));

    always #12.5 i_clk = ~i_clk;

    task automatic final_report();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) fail($sformatf("%s got %h want %h", m, got, exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp) fail($sformatf("%s got %b want %b", m, got, exp));
    endtask

    task automatic chk_cnt(input int got, input int exp, input string m);
        checked++;
        if (got != exp) fail($sformatf("%s got %0d want %0d", m, got, exp));
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("bus hang");
            final_report();
        end
    endtask

    // entered just after a rising edge; waits are bounded, never a fixed count
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        i_hsel <= 1'b1;
        i_haddr <= a;
        i_htrans <= 2'b10;
        i_hwrite <= wr;
        wait_ready();
        i_htrans <= 2'b00;
        i_hsel <= 1'b0;
        i_hwdata <= {24'h000000, wd};
        wait_ready();
        rd = o_hrdata;
        chk_bit(o_hresp, 1'b0, "bus response");
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string m);
        bus(1'b0, a, 8'h00);
        chk_reg(rd, {24'h000000, exp}, m);
    endtask

    task automatic rst(input logic [7:0] opt);
        i_rstn <= 1'b0;
        i_stored_options_byte <= opt;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask

    // skip two ticks so a stale count from the old setting is not measured
    task automatic tick_period(input int exp);
        int n;
        for (int t = 0; t < 3; t++) begin
            n = 0;
            do begin
                @(posedge i_clk);
                n++;
            end while (o_timing_tick !== 1'b1 && n < 2000);
        end
        chk_cnt(n, exp, "tick period");
        if (n >= 2000) final_report();
    endtask

    task automatic arr_write(input logic exp_key, input logic exp_cmd);
        i_array_write <= 1'b1;
        @(posedge i_clk);
        i_array_write <= 1'b0;
        @(posedge i_clk);
        chk_bit(o_key_write, exp_key, "key write pulse");
        chk_bit(o_cmd_write_start, exp_cmd, "command start pulse");
        @(posedge i_clk);
        chk_bit(o_key_write | o_cmd_write_start, 1'b0, "pulse too long");
    endtask

    initial begin
        i_clk = 1'b0;
        i_rstn = 1'b0;
        i_ce = 1'b1;
        i_hsel = 1'b0;
        i_haddr = 12'h000;
        i_htrans = 2'b00;
        i_hwrite = 1'b0;
        i_hsize = 3'h2;
        i_hwdata = 32'h00000000;
        i_stored_options_byte = 8'h00;
        i_key_unlock = 1'b0;
        i_array_write = 1'b0;
        i_array_read = 1'b0;
        n_fail = 0;
        checked = 0;
        @(posedge i_clk);
        // reserved stored bits set on purpose: they must read back as zero
        rst(8'hBD);
        chk_bit(o_backdoor_enabled, 1'b1, "backdoor enabled");
        chk_bit(o_secured, 1'b1, "secured");
        rd_chk(fdsr_pkg::ADDR_DIVIDER, 8'h00, "divider fresh");
        bus(1'b1, fdsr_pkg::ADDR_DIVIDER, 8'h81);
        rd_chk(fdsr_pkg::ADDR_DIVIDER, 8'h81, "divider open");
        tick_period(2);
        bus(1'b1, fdsr_pkg::ADDR_DIVIDER, 8'h43);
        rd_chk(fdsr_pkg::ADDR_DIVIDER, 8'hC3, "divider second");
        tick_period(32);
        bus(1'b1, fdsr_pkg::ADDR_DIVIDER, 8'h85);
        rd_chk(fdsr_pkg::ADDR_DIVIDER, 8'hC3, "divider locked");
        tick_period(32);
        // frozen block must hold the bus off and keep the tick still
        i_ce <= 1'b0;
        repeat (2) @(posedge i_clk);
        k[0] = o_timing_tick;
        m = 0;
        repeat (64) begin
            @(posedge i_clk);
            if (o_timing_tick !== k[0]) m++;
        end
        chk_cnt(m, 0, "tick moved while frozen");
        chk_bit(o_hreadyout, 1'b0, "bus not held while frozen");
        i_ce <= 1'b1;
        rd_chk(fdsr_pkg::ADDR_OPTIONS, 8'h81, "options load");
        bus(1'b1, fdsr_pkg::ADDR_OPTIONS, 8'hC3);
        rd_chk(fdsr_pkg::ADDR_OPTIONS, 8'h81, "options write");
        rd_chk(12'h00C, 8'h00, "unmapped read");
        bus(1'b1, fdsr_pkg::ADDR_CONFIG, 8'hFF);
        rd_chk(fdsr_pkg::ADDR_CONFIG, 8'h20, "config set");
        chk_bit(o_key_write_access, 1'b1, "key access level");
        arr_write(1'b1, 1'b0);
        i_array_read <= 1'b1;
        @(posedge i_clk);
        chk_bit(o_array_read_grant, 1'b1, "array read grant");
        i_array_read <= 1'b0;
        bus(1'b1, fdsr_pkg::ADDR_CONFIG, 8'h00);
        arr_write(1'b0, 1'b1);
        i_key_unlock <= 1'b1;
        @(posedge i_clk);
        i_key_unlock <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk_bit(o_secured, 1'b0, "unlock clears secured");
        rd_chk(fdsr_pkg::ADDR_OPTIONS, 8'h83, "unlock forces field");
        // every enable code paired with its inverted security code, each from a fresh reset
        for (int j = 0; j < 4; j++) begin
            k = j[1:0];
            rst({k, 4'hA, ~k});
            chk_bit(o_backdoor_enabled, k == 2'b10, "backdoor code");
            chk_bit(o_secured, k == 2'b01 || k == 2'b10, "security code");
            rd_chk(fdsr_pkg::ADDR_OPTIONS, {k, 4'h0, ~k}, "options code");
            bus(1'b1, fdsr_pkg::ADDR_CONFIG, 8'h20);
            rd_chk(fdsr_pkg::ADDR_CONFIG, (k == 2'b10) ? 8'h20 : 8'h00, "config gate");
            arr_write(k == 2'b10, k != 2'b10);
            if (j == 0) begin
                // 8 * 32 bus clocks per tick keeps the timing clock in range
                bus(1'b1, fdsr_pkg::ADDR_DIVIDER, 8'h5F);
                tick_period(256);
            end
        end
        bus(1'b1, fdsr_pkg::ADDR_DIVIDER, 8'h7F);
        rd_chk(fdsr_pkg::ADDR_DIVIDER, 8'hFF, "divider max");
        tick_period(512);
        final_report();
    end
endmodule
`default_nettype wire
